// [src/qdrc_consts.svh]
// Register offsets, field positions and opcodes for the queued read block
`ifndef QDRC_CONSTS_SVH
`define QDRC_CONSTS_SVH
// Register byte offsets (one word each)
`define QDRC_OFF_LEN      8'h00
`define QDRC_OFF_TAG      8'h04
`define QDRC_OFF_ADDR_LO  8'h08
`define QDRC_OFF_ADDR_MID 8'h0C
`define QDRC_OFF_ADDR_HI  8'h10
`define QDRC_OFF_DRIVE    8'h14
`define QDRC_OFF_OPCODE   8'h18
`define QDRC_OFF_FAIL     8'h1C
`define QDRC_OFF_STATE    8'h20
`define QDRC_OFF_CTRL     8'h24
`define QDRC_OFF_EVENT    8'h28
`define QDRC_OFF_SECTORS  8'h2C
// Opcodes
`define QDRC_OP_QREAD     8'hC7
`define QDRC_OP_RESUME    8'hA2
`define QDRC_OP_MEDIA_Q   8'hDA
// Tag and reason fields
`define QDRC_TAG_HI       7
`define QDRC_TAG_LO       3
`define QDRC_REL_BIT      2
`define QDRC_DIR_BIT      1
`define QDRC_CD_BIT       0
// Status bits
`define QDRC_ST_OCC       7
`define QDRC_ST_RDY       6
`define QDRC_ST_FAULT     5
`define QDRC_ST_SERVICE_PENDING_FLAG      4
`define QDRC_ST_XFER      3
`define QDRC_ST_CHECK     0
// Failure cause bits
`define QDRC_ER_CRC       7
`define QDRC_ER_UNC       6
`define QDRC_ER_MC        5
`define QDRC_ER_ADDRESS_NOT_FOUND      4
`define QDRC_ER_MCR       3
`define QDRC_ER_ABORT_BIT      2
`define QDRC_ER_NM        1
// Drive register
`define QDRC_DRV_LINEAR   6
// Control register bits
`define QDRC_CT_OVLP      0
`define QDRC_CT_QUEUE     1
`define QDRC_CT_ULTRA     2
// Event register bits (device back end)
`define QDRC_EV_READY     0
`define QDRC_EV_DONE      1
`define QDRC_EV_UNREC     2
`define QDRC_EV_CRC       3
`define QDRC_EV_FAULT     4
`define QDRC_EV_OTHER     5
`define QDRC_EV_NOMED     6
`define QDRC_EV_RANGE     7
`define QDRC_EV_SWAP      8
`define QDRC_EV_MCREQ     9
`define QDRC_EV_GEOFAIL   10
`define QDRC_EV_GEOOK     11
`define QDRC_EV_RELEASE   12
`define QDRC_EV_BADTAG    13
`define QDRC_FULL_COUNT   9'h100
`endif

// [src/qdrc_pkg.sv]
// Types for the queued read command block
package qdrc_pkg;
	typedef enum logic [2:0] {
		QDRC_IDLE,
		QDRC_XFER,
		QDRC_RELEASED,
		QDRC_SERVICE,
		QDRC_DONE,
		QDRC_ERROR
	} qdrc_phase_e;
endpackage : qdrc_pkg

// [src/qdrc_core.sv]
// Queued tagged read command interpreter with Wishbone register slave
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "qdrc_consts.svh"
module qdrc_core (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// Wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// Data mover
	output logic             o_move_start,
	output logic [27:0]      o_move_addr,
	output logic [8:0]       o_move_count,
	output logic             o_move_linear,
	output logic             o_queue_abort
);
	logic [7:0]  len_reg, tag_reg, lo_reg, mid_reg, hi_reg, drv_reg, fail_reg, state_reg;
	logic [2:0]  ctrl_reg;
	logic        change_seen_reg, mcr_reg, geo_bad_reg, prepared_reg, wb_ack_reg;
	logic [31:0] rd_reg;
	logic        move_reg, qabort_reg;
	qdrc_pkg::qdrc_phase_e phase_reg;
	logic        wr, rd, ev_wr, op_wr;
	logic [13:0] ev;
	wire         xfer_ok = wr && i_wb_sel[0];

	// ************
	// Bus decode
	// ************
	always_comb begin
		wr    = i_wb_cyc && i_wb_stb && i_wb_we && !wb_ack_reg;
		rd    = i_wb_cyc && i_wb_stb && !i_wb_we && !wb_ack_reg;
		ev_wr = wr && (i_wb_adr == `QDRC_OFF_EVENT);
		op_wr = xfer_ok && (i_wb_adr == `QDRC_OFF_OPCODE);
		ev    = ev_wr ? i_wb_dat[13:0] : 14'h0000;
	end

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		case (a)
			`QDRC_OFF_TAG:      rd_mux = {24'h000000, tag_reg};
			`QDRC_OFF_ADDR_LO:  rd_mux = {24'h000000, lo_reg};
			`QDRC_OFF_ADDR_MID: rd_mux = {24'h000000, mid_reg};
			`QDRC_OFF_ADDR_HI:  rd_mux = {24'h000000, hi_reg};
			`QDRC_OFF_DRIVE:    rd_mux = {24'h000000, drv_reg};
			`QDRC_OFF_FAIL:     rd_mux = {24'h000000, fail_reg};
			`QDRC_OFF_STATE:    rd_mux = {24'h000000, state_reg};
			`QDRC_OFF_CTRL:     rd_mux = {29'h0000000, ctrl_reg};
			`QDRC_OFF_SECTORS:  rd_mux = {23'h000000, o_move_count};
			default:            rd_mux = 32'h00000000;
		endcase
	endfunction : rd_mux

	// Ack after one cycle, dropped the cycle after
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			wb_ack_reg <= 1'b0;
			rd_reg     <= 32'h00000000;
		end else begin
			wb_ack_reg <= (wr || rd);
			rd_reg     <= rd ? rd_mux(i_wb_adr) : 32'h00000000;
		end
	end
	assign o_wb_dat = rd_reg;
	assign o_wb_ack = wb_ack_reg;

	// ************
	// Host loaded registers
	// ************
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			len_reg  <= 8'h00;
			ctrl_reg <= 3'h0;
		end else if (xfer_ok) begin
			if (i_wb_adr == `QDRC_OFF_LEN)
				len_reg <= i_wb_dat[7:0];
			if (i_wb_adr == `QDRC_OFF_CTRL)
				ctrl_reg <= i_wb_dat[2:0];
		end
	end

	// Media side sticky state; set wins over clear
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			change_seen_reg <= 1'b0;
			mcr_reg         <= 1'b0;
			geo_bad_reg     <= 1'b0;
		end else begin
			if (ev[`QDRC_EV_SWAP])
				change_seen_reg <= 1'b1;
			else if (phase_reg == qdrc_pkg::QDRC_ERROR)
				change_seen_reg <= 1'b0;
			if (ev[`QDRC_EV_MCREQ])
				mcr_reg <= 1'b1;
			else if (op_wr && (i_wb_dat[7:0] == `QDRC_OP_MEDIA_Q
				|| i_wb_dat[7:0] == `QDRC_OP_QREAD))
				mcr_reg <= 1'b0;
			if (ev[`QDRC_EV_GEOFAIL])
				geo_bad_reg <= 1'b1;
			else if (ev[`QDRC_EV_GEOOK])
				geo_bad_reg <= 1'b0;
		end
	end

	// ************
	// Command phases
	// ************
	wire [7:0] opc     = i_wb_dat[7:0];
	wire       tag_bad = ctrl_reg[`QDRC_CT_QUEUE] && ev[`QDRC_EV_BADTAG];
	wire [7:0] tag_fld = ctrl_reg[`QDRC_CT_QUEUE] ? {tag_reg[7:3], 3'b000} : 8'h00;
	wire       other   = ev[`QDRC_EV_OTHER];
	// Live event bits count too, else a same-cycle swap or request is lost
	wire [7:0] xfer_fail = {ev[`QDRC_EV_CRC] && ctrl_reg[`QDRC_CT_ULTRA],
		ev[`QDRC_EV_UNREC], change_seen_reg | ev[`QDRC_EV_SWAP],
		ev[`QDRC_EV_RANGE] | geo_bad_reg, mcr_reg | ev[`QDRC_EV_MCREQ],
		ev[`QDRC_EV_CRC], ev[`QDRC_EV_NOMED], 1'b0};

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			phase_reg    <= qdrc_pkg::QDRC_IDLE;
			state_reg    <= 8'h40;
			fail_reg     <= 8'h00;
			tag_reg      <= 8'h00;
			lo_reg       <= 8'h00;
			mid_reg      <= 8'h00;
			hi_reg       <= 8'h00;
			drv_reg      <= 8'h00;
			prepared_reg <= 1'b0;
			move_reg     <= 1'b0;
			qabort_reg   <= 1'b0;
			o_move_addr  <= 28'h0000000;
			o_move_count <= 9'h000;
			o_move_linear <= 1'b0;
		end else begin
			move_reg   <= 1'b0;
			qabort_reg <= 1'b0;
			if (xfer_ok && phase_reg == qdrc_pkg::QDRC_IDLE) begin
				unique case (i_wb_adr)
					`QDRC_OFF_TAG:      tag_reg <= i_wb_dat[7:0];
					`QDRC_OFF_ADDR_LO:  lo_reg  <= i_wb_dat[7:0];
					`QDRC_OFF_ADDR_MID: mid_reg <= i_wb_dat[7:0];
					`QDRC_OFF_ADDR_HI:  hi_reg  <= i_wb_dat[7:0];
					`QDRC_OFF_DRIVE:    drv_reg <= i_wb_dat[7:0];
					default: ;
				endcase
			end
			unique case (phase_reg)
				qdrc_pkg::QDRC_IDLE, qdrc_pkg::QDRC_DONE, qdrc_pkg::QDRC_ERROR: begin
					if (op_wr) begin
						if (opc != `QDRC_OP_QREAD || !ctrl_reg[`QDRC_CT_OVLP]) begin
							fail_reg  <= 8'h04;
							state_reg <= 8'h41;
							tag_reg   <= {tag_fld[7:3], 3'b011};
							phase_reg <= qdrc_pkg::QDRC_ERROR;
						end else begin
							o_move_count  <= (len_reg == 8'h00) ?
								`QDRC_FULL_COUNT : {1'b0, len_reg};
							o_move_addr   <= {drv_reg[3:0], hi_reg, mid_reg, lo_reg};
							o_move_linear <= drv_reg[`QDRC_DRV_LINEAR];
							state_reg     <= 8'h80;
							fail_reg      <= 8'h00;
							phase_reg     <= qdrc_pkg::QDRC_SERVICE;
						end
					end
				end
				qdrc_pkg::QDRC_SERVICE: begin
					// Decision point after command or resume
					if (tag_bad) begin
						fail_reg  <= 8'h04;
						state_reg <= 8'h41;
						tag_reg   <= {tag_fld[7:3], 3'b011};
						phase_reg <= qdrc_pkg::QDRC_ERROR;
					end else if (ev[`QDRC_EV_RANGE] || geo_bad_reg) begin
						fail_reg  <= 8'h10;
						state_reg <= 8'h41;
						tag_reg   <= {tag_fld[7:3], 3'b011};
						phase_reg <= qdrc_pkg::QDRC_ERROR;
					end else if (ev[`QDRC_EV_READY] || prepared_reg) begin
						state_reg <= {3'b010, other, 1'b1, 3'b000};
						tag_reg   <= {tag_fld[7:3], 3'b010};
						move_reg  <= 1'b1;
						prepared_reg <= 1'b0;
						phase_reg <= qdrc_pkg::QDRC_XFER;
					end else if (ev[`QDRC_EV_RELEASE]) begin
						state_reg <= {3'b010, other | prepared_reg, 4'b0000};
						tag_reg   <= {tag_fld[7:3], 3'b100};
						phase_reg <= qdrc_pkg::QDRC_RELEASED;
					end
				end
				qdrc_pkg::QDRC_RELEASED: begin
					if (ev[`QDRC_EV_READY] || ev[`QDRC_EV_OTHER]) begin
						state_reg[`QDRC_ST_SERVICE_PENDING_FLAG] <= 1'b1;
						prepared_reg <= prepared_reg | ev[`QDRC_EV_READY];
					end
					if (op_wr && opc == `QDRC_OP_RESUME)
						phase_reg <= qdrc_pkg::QDRC_SERVICE;
				end
				qdrc_pkg::QDRC_XFER: begin
					if (ev[`QDRC_EV_UNREC] || ev[`QDRC_EV_CRC] || ev[`QDRC_EV_FAULT]
						|| ev[`QDRC_EV_NOMED]) begin
						fail_reg  <= xfer_fail;
						state_reg <= {2'b01, ev[`QDRC_EV_FAULT], other, 3'b000,
							|xfer_fail};
						tag_reg   <= {tag_fld[7:3], 3'b011};
						lo_reg    <= i_wb_dat[15:8];
						mid_reg   <= i_wb_dat[23:16];
						hi_reg    <= {4'h0, i_wb_dat[27:24]};
						qabort_reg <= ev[`QDRC_EV_UNREC];
						phase_reg <= qdrc_pkg::QDRC_ERROR;
					end else if (ev[`QDRC_EV_DONE]) begin
						fail_reg  <= 8'h00;
						state_reg <= {3'b010, other, 4'b0000};
						tag_reg   <= {tag_fld[7:3], 3'b011};
						phase_reg <= qdrc_pkg::QDRC_DONE;
					end
				end
				default: phase_reg <= qdrc_pkg::QDRC_IDLE;
			endcase
		end
	end
	assign o_move_start  = move_reg;
	assign o_queue_abort = qabort_reg;

	// ************
	// Checks
	// ************
	a_abort_on_op: assert property (@(posedge i_clock) disable iff (i_rst)
		(op_wr && phase_reg == qdrc_pkg::QDRC_IDLE && !ctrl_reg[`QDRC_CT_OVLP])
		|=> fail_reg[`QDRC_ER_ABORT_BIT] && state_reg[`QDRC_ST_CHECK])
		else $error("abort not reported");
	a_xfer_state: assert property (@(posedge i_clock) disable iff (i_rst)
		(phase_reg == qdrc_pkg::QDRC_XFER) |-> state_reg[`QDRC_ST_XFER]
		&& !state_reg[`QDRC_ST_OCC] && tag_reg[2:0] == 3'b010)
		else $error("data phase state wrong");
	a_release_flags: assert property (@(posedge i_clock) disable iff (i_rst)
		$rose(phase_reg == qdrc_pkg::QDRC_RELEASED) |-> tag_reg[2:0] == 3'b100
		&& !state_reg[`QDRC_ST_XFER])
		else $error("release flags wrong");
	a_done_clean: assert property (@(posedge i_clock) disable iff (i_rst)
		(phase_reg == qdrc_pkg::QDRC_DONE) |-> fail_reg == 8'h00 && tag_reg[2:0] == 3'b011)
		else $error("completion state wrong");
	a_start_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
		o_move_start |-> phase_reg == qdrc_pkg::QDRC_XFER ##1 !o_move_start)
		else $error("start pulse wrong");
	a_count_full: assert property (@(posedge i_clock) disable iff (i_rst)
		(op_wr && opc == `QDRC_OP_QREAD && ctrl_reg[0] && len_reg == 8'h00
		&& phase_reg == qdrc_pkg::QDRC_IDLE) |=> o_move_count == 9'h100)
		else $error("zero length not 256");
	a_err_summary: assert property (@(posedge i_clock) disable iff (i_rst)
		$rose(phase_reg == qdrc_pkg::QDRC_ERROR) |-> state_reg[`QDRC_ST_CHECK]
		== (fail_reg != 8'h00) && state_reg[`QDRC_ST_RDY])
		else $error("error summary wrong");
	a_ack_one: assert property (@(posedge i_clock) disable iff (i_rst)
		o_wb_ack |=> !o_wb_ack)
		else $error("ack held too long");
	c_release: cover property (@(posedge i_clock) phase_reg == qdrc_pkg::QDRC_RELEASED);
	c_done: cover property (@(posedge i_clock) phase_reg == qdrc_pkg::QDRC_DONE);
	c_error: cover property (@(posedge i_clock) phase_reg == qdrc_pkg::QDRC_ERROR);
endmodule : qdrc_core

// [verif/qdrc_host_model.sv]
// Host controller model: Wishbone master for the command block
`timescale 1ns/1ps
`include "qdrc_consts.svh"
module qdrc_host_model (
	// Clock
	input  wire logic        i_clock,
	// Wishbone master
	input  wire logic [31:0] i_wb_dat,
	input  wire logic        i_wb_ack,
	output logic             o_wb_cyc,
	output logic             o_wb_stb,
	output logic             o_wb_we,
	output logic [7:0]       o_wb_adr,
	output logic [3:0]       o_wb_sel,
	output logic [31:0]      o_wb_dat
);
	initial begin
		o_wb_cyc = 1'b0;
		o_wb_stb = 1'b0;
		o_wb_we  = 1'b0;
		o_wb_adr = 8'h00;
		o_wb_sel = 4'h0;
		o_wb_dat = 32'h0;
	end
	// Released address and data lines show the inverse so stale values never match
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge i_clock);
		o_wb_cyc <= 1'b1;
		o_wb_stb <= 1'b1;
		o_wb_we  <= w;
		o_wb_adr <= a;
		o_wb_sel <= 4'hF;
		o_wb_dat <= d;
		do @(posedge i_clock); while (i_wb_ack !== 1'b1);
		q = i_wb_dat;
		o_wb_cyc <= 1'b0;
		o_wb_stb <= 1'b0;
		o_wb_we  <= 1'b0;
		o_wb_adr <= ~a;
		o_wb_dat <= ~d;
	endtask : xfer
	// Opcode only once the unit reports ready
	task automatic issue(input logic [7:0] op);
		logic [31:0] q;
		do xfer(1'b0, `QDRC_OFF_STATE, 32'h0, q); while (q[6] !== 1'b1);
		xfer(1'b1, `QDRC_OFF_OPCODE, {24'h0, op}, q);
	endtask : issue
endmodule : qdrc_host_model

// [verif/tb_top.sv]
// Self-checking bench for the queued read command block
`timescale 1ns/1ps
`include "qdrc_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
	typedef struct {logic [7:0] len; logic [4:0] tag; logic [7:0] drv, lo, mid, hi;
		logic oth; logic [8:0] cnt;} qdrc_row_s;
	logic        clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        cyc, stb, we, ack, mv_start, mv_lin, qabort;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic [27:0] mv_addr;
	logic [8:0]  mv_cnt;
	logic [7:0]  v;
	int          failures = 0;
	int          checks_done = 0;
	int          starts = 0;
	int          aborts = 0;
	int          s0;
	qdrc_row_s   rows [3] = '{
		'{8'h00, 5'd0, 8'h4A, 8'h11, 8'h22, 8'h33, 1'b0, 9'h100},
		'{8'h01, 5'd31, 8'h05, 8'hFF, 8'h00, 8'h80, 1'b1, 9'h001},
		'{8'hFF, 5'd17, 8'h40, 8'h00, 8'h00, 8'h00, 1'b0, 9'h0FF}};
	initial forever #10 clk = ~clk;
	qdrc_host_model u_host (.i_clock(clk), .i_wb_dat(rdat), .i_wb_ack(ack), .o_wb_cyc(cyc),
		.o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat));
	qdrc_core u_dut (.i_clock(clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .o_move_start(mv_start), .o_move_addr(mv_addr),
		.o_move_count(mv_cnt), .o_move_linear(mv_lin), .o_queue_abort(qabort));
	always @(posedge clk) begin
		if (mv_start === 1'b1) starts++;
		if (qabort === 1'b1) aborts++;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_host.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic [31:0] q;
		u_host.xfer(1'b0, a, 32'h0, q);
		v = q[7:0];
	endtask : rd
	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		`CHK(v, e);
	endtask : chk
	task automatic do_reset;
		i_rst <= 1'b1;
		repeat (10) @(posedge clk);
		i_rst <= 1'b0;
	endtask : do_reset
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// ************
	// Watchdog
	// ************
	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		print_verdict();
	end
	// ************
	// Tests
	// ************
	initial begin
		foreach (rows[i]) begin
			do_reset();
			wr(`QDRC_OFF_CTRL, 32'h3);
			wr(`QDRC_OFF_LEN, {24'h0, rows[i].len});
			wr(`QDRC_OFF_TAG, {24'h0, rows[i].tag, 3'b000});
			wr(`QDRC_OFF_ADDR_LO, {24'h0, rows[i].lo});
			wr(`QDRC_OFF_ADDR_MID, {24'h0, rows[i].mid});
			wr(`QDRC_OFF_ADDR_HI, {24'h0, rows[i].hi});
			wr(`QDRC_OFF_DRIVE, {24'h0, rows[i].drv});
			u_host.issue(`QDRC_OP_QREAD);
			chk(`QDRC_OFF_STATE, 8'h80);
			`CHK(mv_cnt, rows[i].cnt);
			`CHK(mv_addr, {rows[i].drv[3:0], rows[i].hi, rows[i].mid, rows[i].lo});
			`CHK(mv_lin, rows[i].drv[6]);
			s0 = starts;
			wr(`QDRC_OFF_EVENT, {26'h0, rows[i].oth, 5'h01});
			chk(`QDRC_OFF_STATE, {3'b010, rows[i].oth, 4'h8});
			chk(`QDRC_OFF_TAG, {rows[i].tag, 3'b010});
			`CHK(starts, s0 + 1);
			wr(`QDRC_OFF_EVENT, 32'h2);
			rd(`QDRC_OFF_STATE);
			`CHK(v & 8'hEF, 8'h40);
			chk(`QDRC_OFF_FAIL, 8'h00);
			chk(`QDRC_OFF_TAG, {rows[i].tag, 3'b011});
		end
		// Reset value and an unmapped read
		do_reset();
		chk(`QDRC_OFF_STATE, 8'h40);
		chk(8'h3C, 8'h00);
		// Overlap not enabled: aborted
		wr(`QDRC_OFF_CTRL, 32'h0);
		u_host.issue(`QDRC_OP_QREAD);
		chk(`QDRC_OFF_FAIL, 8'h04);
		chk(`QDRC_OFF_STATE, 8'h41);
		// Release, service request, resume
		do_reset();
		wr(`QDRC_OFF_CTRL, 32'h3);
		wr(`QDRC_OFF_TAG, {24'h0, 5'd9, 3'b000});
		u_host.issue(`QDRC_OP_QREAD);
		wr(`QDRC_OFF_EVENT, 32'h1000);
		chk(`QDRC_OFF_TAG, {5'd9, 3'b100});
		chk(`QDRC_OFF_STATE, 8'h40);
		wr(`QDRC_OFF_EVENT, 32'h1);
		chk(`QDRC_OFF_STATE, 8'h50);
		chk(`QDRC_OFF_TAG, {5'd9, 3'b100});
		u_host.issue(`QDRC_OP_RESUME);
		chk(`QDRC_OFF_STATE, 8'h48);
		chk(`QDRC_OFF_TAG, {5'd9, 3'b010});
		// Every error cause at once, fast mode, then medium query
		do_reset();
		wr(`QDRC_OFF_CTRL, 32'h7);
		u_host.issue(`QDRC_OP_QREAD);
		wr(`QDRC_OFF_EVENT, 32'h1);
		s0 = aborts;
		wr(`QDRC_OFF_EVENT, 32'h000003DC | (32'h00ABCDE << 8));
		chk(`QDRC_OFF_FAIL, 8'hFE);
		`CHK(aborts, s0 + 1);
		chk(`QDRC_OFF_STATE, 8'h61);
		chk(`QDRC_OFF_ADDR_LO, 8'hDF);
		chk(`QDRC_OFF_ADDR_MID, 8'hBC);
		chk(`QDRC_OFF_ADDR_HI, 8'h0A);
		u_host.issue(`QDRC_OP_MEDIA_Q);
		rd(`QDRC_OFF_FAIL);
		`CHK(v[3], 1'b0);
		// Change request kept until a media query or queued read opcode
		do_reset();
		wr(`QDRC_OFF_CTRL, 32'h3);
		wr(`QDRC_OFF_TAG, {24'h0, 5'd21, 3'b000});
		u_host.issue(`QDRC_OP_QREAD);
		wr(`QDRC_OFF_EVENT, 32'h200);
		wr(`QDRC_OFF_EVENT, 32'h1);
		wr(`QDRC_OFF_EVENT, 32'h4);
		chk(`QDRC_OFF_FAIL, 8'h48);
		chk(`QDRC_OFF_TAG, {5'd21, 3'b011});
		// Out of range, bad tag, failed then good geometry
		u_host.issue(`QDRC_OP_QREAD);
		wr(`QDRC_OFF_EVENT, 32'h80);
		chk(`QDRC_OFF_FAIL, 8'h10);
		u_host.issue(`QDRC_OP_QREAD);
		wr(`QDRC_OFF_EVENT, 32'h2000);
		chk(`QDRC_OFF_FAIL, 8'h04);
		wr(`QDRC_OFF_EVENT, 32'h400);
		u_host.issue(`QDRC_OP_QREAD);
		chk(`QDRC_OFF_FAIL, 8'h10);
		wr(`QDRC_OFF_EVENT, 32'h800);
		u_host.issue(`QDRC_OP_QREAD);
		chk(`QDRC_OFF_STATE, 8'h80);
		// No queuing: released tag field reads zeros
		wr(`QDRC_OFF_CTRL, 32'h1);
		wr(`QDRC_OFF_EVENT, 32'h1020);
		chk(`QDRC_OFF_TAG, 8'h04);
		chk(`QDRC_OFF_STATE, 8'h50);
		print_verdict();
	end
endmodule : tb_top
